// ==== hdl/rbc_params.svh ====
// rbc_params.svh: offsets of bits, pin level codes, event codes and timing counts
// assumes three-level pins arrive as two-bit codes from the pad decoders
`ifndef RBC_PARAMS_SVH
`define RBC_PARAMS_SVH
// three-level pin codes
`define RBC_LVL_LOW 2'h0
`define RBC_LVL_MID 2'h1
`define RBC_LVL_HIGH 2'h2
// events carried on the bond status bus
`define RBC_EV_NONE 2'h0
`define RBC_EV_INS 2'h1
`define RBC_EV_DEL 2'h2
`define RBC_EV_ALIGN 2'h3
// receive enable of channel n sits at bit 2n plus this offset
`define RBC_RX_EN_BIT 1
`define RBC_CHAN_EN_RST 8'h00
// timing
`define RBC_CLK_NS 50
`define RBC_REEN_NS 2000000
`define RBC_REEN_CYC ((`RBC_REEN_NS + `RBC_CLK_NS - 1) / `RBC_CLK_NS)
`define RBC_SYNC_MIN_FRAMING 4
`endif

// ==== hdl/rbc_pkg.sv ====
// rbc_pkg: types shared by the receive bonding control modules
// assumes nothing of its surroundings
package rbc_pkg;
  typedef enum logic [2:0] {CS_REF, CS_REC_A, CS_REC_B, CS_REC_C, CS_REC_D, CS_OWN} rbc_clk_src_t;
  typedef enum logic [1:0] {BM_INDEP, BM_DUAL, BM_QUAD} rbc_bond_mode_t;
  typedef enum logic [1:0] {ST_UNBONDED, ST_ALIGNING, ST_BONDED} rbc_state_t;
endpackage : rbc_pkg

// ==== hdl/rbc_xing_if.sv ====
// rbc_xing_if: event crossing from the link clock logic to the core
// assumes the core synchronises the toggle before use
`timescale 1ns/1ns
interface rbc_xing_if;
  logic sync_tgl;
  modport link (output sync_tgl);
  modport core (input sync_tgl);
endinterface : rbc_xing_if

// ==== hdl/rbc_sync.sv ====
// rbc_sync: two flip-flop level synchroniser
// assumes the input is a level held for several destination edges
`timescale 1ns/1ns
module rbc_sync #(
  parameter int W = 1
) (
  // destination clock
  input wire logic clk,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // no reset: the first stage only feeds the second
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end
endmodule : rbc_sync

// ==== hdl/rbc_link.sv ====
// rbc_link: word sync detection on the master recovered clock
// assumes framing_seen is one link cycle per framing character; the clock may stop
`timescale 1ns/1ns
`include "rbc_params.svh"
module rbc_link
  import rbc_pkg::*;
(
  // link clock and the core reset
  input wire logic link_clk,
  input wire logic rst_n,
  // framer of the master channel
  input wire logic framing_seen,
  // toward the core
  rbc_xing_if.link xing
);
  logic rst_s;
  logic [2:0] cnt_reg;
  logic tgl_reg;

  rbc_sync #(.W(1)) u_rst_sync (.clk(link_clk), .d(rst_n), .q(rst_s));

  // consecutive framing characters centre the buffers; a toggle carries the event
  always_ff @(posedge link_clk) begin
    if (!rst_s) begin
      cnt_reg <= 3'h0;
      tgl_reg <= 1'b0;
    end else if (!framing_seen) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg == 3'(`RBC_SYNC_MIN_FRAMING - 1)) begin
      cnt_reg <= 3'h0;
      tgl_reg <= ~tgl_reg;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  assign xing.sync_tgl = tgl_reg;
endmodule : rbc_link

// ==== hdl/rbc_ctrl.sv ====
// rbc_ctrl: receive channel bonding control for a four channel receiver
// assumes pins are asynchronous, buffer requests are on clock, framing on link_clk
//
// Contract
// - dual bonding: each pair's output registers share one clock; inhibited at MID
// - before alignment outputs flow but word boundaries are not guaranteed
// - source LOW: reference clock for all, B/D clocks off, buffers on
// - dual on reference: pair inserts and deletes together, led by pair select
// - dual recovered: A/B from A or B on clock A, C/D on clock C
// - recovered clock: no insert or delete except for buffer alignment
// - quad bonding: all four output registers share one clock; inhibited at MID
// - quad on reference: all four insert and delete together, led by master
// - quad recovered: one chosen recovered clock on clocks A and C
// - multi-device bonding only in quad mode on the reference clock
// - bond status buses tied together carry buffer events between devices
// - in the controller the master channel generates the status bus values
// - bond complete is a wired-AND held low until resolution finishes
// - strobe high passes enable bus to channel power; low holds it
// - disabled master stops insert/delete and clock select; fault stays asserted
// - after re-enable, fault and data are suspect for up to 2 ms
// - selects decode 00 A, 01 B, 10 C, 11 D
// - reset clears the receive enable latch
`timescale 1ns/1ns
`include "rbc_params.svh"
module rbc_ctrl
  import rbc_pkg::*;
#(
  parameter int unsigned REEN_CYC = `RBC_REEN_CYC
) (
  // clocks and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  // configuration pins, mode and source as two-bit level codes
  input wire logic [3:0] receive_bonding_mode_select,
  input wire logic [1:0] receive_clock_source_select,
  input wire logic pair_ab_clock_select,
  input wire logic pair_cd_clock_select,
  input wire logic controller_select_n,
  // power latch pins
  input wire logic receive_enable_latch_strobe,
  input wire logic [7:0] channel_enable_bus,
  // elasticity buffer side, on clock
  input wire logic [3:0] ebuf_ins_req,
  input wire logic [3:0] ebuf_del_req,
  input wire logic [3:0] chan_fault_in,
  // master channel framer, on link_clk
  input wire logic link_framing_seen,
  // bond status bus pins
  input wire logic [1:0] bond_status_bus_i,
  output logic [1:0] bond_status_bus_o,
  output logic bond_status_bus_oe,
  // wired-AND bond complete pin
  input wire logic bond_complete_i,
  output logic bond_complete_o,
  output logic bond_complete_oe,
  // buffer control
  output logic [3:0] ebuf_ins_cmd,
  output logic [3:0] ebuf_del_cmd,
  output logic ebuf_enable,
  // output clock steering
  output rbc_clk_src_t output_clock_a_src,
  output rbc_clk_src_t output_clock_c_src,
  output logic output_clock_bd_oe,
  output logic clock_select_valid,
  // channel state
  output logic [3:0] receive_power_en,
  output logic [3:0] link_fault_indicator,
  output logic [3:0] output_data_suspect,
  output logic words_aligned,
  output logic bond_inhibit,
  output logic all_devices_bonded
);
  localparam int CNT_W = $clog2(REEN_CYC + 1);

  // refuse counts the suspect counter cannot hold
  if (REEN_CYC < 1 || CNT_W > 24) begin : g_chk
    $error("rbc_ctrl: REEN_CYC out of range");
  end

  rbc_xing_if xing ();
  rbc_link u_link (.link_clk(link_clk), .rst_n(rst_n), .framing_seen(link_framing_seen), .xing(xing));

  // every pin passes two flops before use
  logic [20:0] pin_raw;
  logic [20:0] pin_s;
  logic [1:0] mode_up, mode_lo, cksel, bst_s;
  logic ab_sel, cd_sel, ctrl_n, le_s, bc_s;
  logic [7:0] en_bus_s;
  assign pin_raw = {receive_bonding_mode_select, receive_clock_source_select, pair_ab_clock_select,
                    pair_cd_clock_select, controller_select_n, receive_enable_latch_strobe,
                    channel_enable_bus, bond_status_bus_i, bond_complete_i};
  rbc_sync #(.W(21)) u_pin_sync (.clk(clock), .d(pin_raw), .q(pin_s));
  assign {mode_up, mode_lo, cksel, ab_sel, cd_sel, ctrl_n, le_s, en_bus_s, bst_s, bc_s} = pin_s;

  // word sync event from the link domain, toggle edge after synchronising
  logic tgl_s, tgl_d_reg, sync_evt;
  rbc_sync #(.W(1)) u_tgl_sync (.clk(clock), .d(xing.sync_tgl), .q(tgl_s));
  // the follower tracks the toggle through reset too: clearing it would fake an event at release
  always_ff @(posedge clock) begin
    tgl_d_reg <= tgl_s;
  end
  assign sync_evt = tgl_s ^ tgl_d_reg;

  // mode decode
  rbc_bond_mode_t bm;
  logic [1:0] qm;
  logic inhibit, multi, is_ctrl;
  always_comb begin
    case (mode_up)
      `RBC_LVL_LOW: bm = BM_INDEP;
      `RBC_LVL_MID: bm = BM_DUAL;
      default: bm = BM_QUAD;
    endcase
  end
  assign qm = {ab_sel, cd_sel};
  // a MID source stops bonding, and the test setting stops bonding and buffer commands in every mode
  assign inhibit = (bm != BM_INDEP && cksel == `RBC_LVL_MID) || mode_lo == `RBC_LVL_MID;
  assign multi = bm == BM_QUAD && cksel == `RBC_LVL_LOW;
  assign is_ctrl = !ctrl_n;

  // which channel leads the buffer events of channel i
  function automatic logic [1:0] master_of(input rbc_bond_mode_t b, input logic [1:0] i,
                                           input logic a, input logic c, input logic [1:0] q);
    case (b)
      BM_DUAL: master_of = i[1] ? {1'b1, c} : {1'b0, a};
      BM_QUAD: master_of = q;
      default: master_of = i;
    endcase
  endfunction : master_of

  function automatic rbc_clk_src_t rec_of(input logic [1:0] c);
    case (c)
      2'h0: rec_of = CS_REC_A;
      2'h1: rec_of = CS_REC_B;
      2'h2: rec_of = CS_REC_C;
      default: rec_of = CS_REC_D;
    endcase
  endfunction : rec_of

  // receive enable latch, transparent while the strobe is high
  logic [7:0] chan_en_reg;
  logic [3:0] pwr;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      chan_en_reg <= `RBC_CHAN_EN_RST;
    end else if (le_s) begin
      chan_en_reg <= en_bus_s;
    end
  end

  // bonding state: any change of configuration restarts alignment
  rbc_state_t state_reg;
  logic [8:0] cfg_reg;
  logic [8:0] cfg_now;
  logic sync_use;
  logic [1:0] own_d1_reg, own_d2_reg, act_ev, bst_nx;
  assign cfg_now = {mode_up, mode_lo, cksel, ab_sel, cd_sel, ctrl_n};
  // in multi-device mode the controller acts on its own bus value one edge before the other devices, which see it through the pin synchroniser
  assign act_ev = is_ctrl ? own_d2_reg : bst_s;
  assign sync_use = multi ? act_ev == `RBC_EV_ALIGN : sync_evt;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_reg <= 9'h000;
      state_reg <= ST_UNBONDED;
    end else begin
      cfg_reg <= cfg_now;
      if (cfg_now != cfg_reg || inhibit) begin
        state_reg <= ST_UNBONDED;
      end else begin
        case (state_reg)
          ST_UNBONDED: state_reg <= ST_ALIGNING;
          ST_ALIGNING: if (sync_use) state_reg <= ST_BONDED;
          ST_BONDED: state_reg <= ST_BONDED;
          default: state_reg <= ST_UNBONDED;
        endcase
      end
    end
  end

  // controller drives events of its master channel on the bus
  always_comb begin
    if (sync_evt) begin
      bst_nx = `RBC_EV_ALIGN;
    end else if (!pwr[qm]) begin
      bst_nx = `RBC_EV_NONE;
    end else if (ebuf_ins_req[qm]) begin
      bst_nx = `RBC_EV_INS;
    end else if (ebuf_del_req[qm]) begin
      bst_nx = `RBC_EV_DEL;
    end else begin
      bst_nx = `RBC_EV_NONE;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bond_status_bus_o <= `RBC_EV_NONE;
      bond_status_bus_oe <= 1'b0;
      own_d1_reg <= `RBC_EV_NONE;
      own_d2_reg <= `RBC_EV_NONE;
    end else begin
      bond_status_bus_o <= bst_nx;
      bond_status_bus_oe <= multi && is_ctrl;
      own_d1_reg <= bst_nx;
      own_d2_reg <= own_d1_reg;
    end
  end

  // per channel: lead channel events, power, fault and re-enable window
  logic [3:0] ins_nx, del_nx, susp_nx;
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic [1:0] m;
    logic [1:0] ev;
    logic allow;
    logic pwr_d_reg;
    logic [CNT_W-1:0] cnt_reg;
    assign pwr[i] = chan_en_reg[2 * i + `RBC_RX_EN_BIT];
    assign m = master_of(bm, 2'(i), ab_sel, cd_sel, qm);
    assign ev = multi ? act_ev : (ebuf_ins_req[m] ? `RBC_EV_INS : (ebuf_del_req[m] ? `RBC_EV_DEL : `RBC_EV_NONE));
    // recovered clock: only alignment moves the buffers; a dead lead stops the channels it leads
    assign allow = !inhibit && pwr[m] && (cksel == `RBC_LVL_LOW ||
                   (cksel == `RBC_LVL_HIGH && state_reg != ST_BONDED));
    assign ins_nx[i] = allow && ev == `RBC_EV_INS;
    assign del_nx[i] = allow && ev == `RBC_EV_DEL;
    assign susp_nx[i] = (pwr[i] && !pwr_d_reg) || cnt_reg > CNT_W'(1);
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        pwr_d_reg <= 1'b0;
        cnt_reg <= '0;
      end else begin
        pwr_d_reg <= pwr[i];
        if (pwr[i] && !pwr_d_reg) begin
          cnt_reg <= CNT_W'(REEN_CYC);
        end else if (cnt_reg != '0) begin
          cnt_reg <= cnt_reg - CNT_W'(1);
        end
      end
    end
  end

  // buffer commands and channel status outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ebuf_ins_cmd <= 4'h0;
      ebuf_del_cmd <= 4'h0;
      receive_power_en <= 4'h0;
      link_fault_indicator <= 4'hf;
      output_data_suspect <= 4'h0;
    end else begin
      ebuf_ins_cmd <= ins_nx;
      ebuf_del_cmd <= del_nx;
      receive_power_en <= pwr;
      link_fault_indicator <= ~pwr | chan_fault_in;
      output_data_suspect <= susp_nx;
    end
  end

  // clock steering: pair A/B registers run from clock A, C/D from clock C
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      output_clock_a_src <= CS_REF;
      output_clock_c_src <= CS_REF;
      output_clock_bd_oe <= 1'b0;
      ebuf_enable <= 1'b0;
      clock_select_valid <= 1'b0;
    end else if (cksel == `RBC_LVL_LOW) begin
      output_clock_a_src <= CS_REF;
      output_clock_c_src <= CS_REF;
      output_clock_bd_oe <= 1'b0;
      ebuf_enable <= 1'b1;
      clock_select_valid <= 1'b1;
    end else if (cksel == `RBC_LVL_MID) begin
      // each channel on its own clock, buffers bypassed
      output_clock_a_src <= CS_OWN;
      output_clock_c_src <= CS_OWN;
      output_clock_bd_oe <= 1'b1;
      ebuf_enable <= 1'b0;
      clock_select_valid <= 1'b1;
    end else if (bm == BM_DUAL) begin
      output_clock_a_src <= ab_sel ? CS_REC_B : CS_REC_A;
      output_clock_c_src <= cd_sel ? CS_REC_D : CS_REC_C;
      output_clock_bd_oe <= 1'b0;
      ebuf_enable <= 1'b1;
      clock_select_valid <= pwr[{1'b0, ab_sel}] && pwr[{1'b1, cd_sel}];
    end else begin
      output_clock_a_src <= rec_of(qm);
      output_clock_c_src <= rec_of(qm);
      output_clock_bd_oe <= 1'b0;
      ebuf_enable <= 1'b1;
      clock_select_valid <= pwr[qm];
    end
  end

  // bonding status and the wired-AND line, which is only ever pulled low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      words_aligned <= 1'b0;
      bond_inhibit <= 1'b0;
      bond_complete_o <= 1'b0;
      bond_complete_oe <= 1'b0;
      all_devices_bonded <= 1'b0;
    end else begin
      words_aligned <= state_reg == ST_BONDED;
      bond_inhibit <= inhibit;
      bond_complete_o <= 1'b0;
      bond_complete_oe <= multi && state_reg != ST_BONDED;
      all_devices_bonded <= bc_s;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_rise0;
    g_ch[0].pwr_d_reg == 1'b0 && pwr[0];
  endsequence
  sequence s_suspect_hold;
    output_data_suspect[0] [*8];
  endsequence

  property p_latch;
    le_s |=> chan_en_reg == $past(en_bus_s);
  endproperty
  a_latch: assert property (p_latch) else $error("enable latch did not follow bus");
  property p_hold;
    !le_s |=> $stable(chan_en_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("enable latch changed while closed");
  property p_rst_clear;
    @(posedge clock) disable iff (1'b0) !rst_n |=> chan_en_reg == 8'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left channels enabled");
  property p_fault;
    !pwr[1] |=> link_fault_indicator[1];
  endproperty
  a_fault: assert property (p_fault) else $error("disabled channel hid its fault");
  property p_reenable;
    s_rise0 |=> ##1 s_suspect_hold;
  endproperty
  a_reenable: assert property (p_reenable) else $error("re-enable window too short");
  property p_dual_pair;
    bm == BM_DUAL && cksel == `RBC_LVL_LOW |=> ebuf_ins_cmd[0] == ebuf_ins_cmd[1] &&
      ebuf_del_cmd[2] == ebuf_del_cmd[3];
  endproperty
  a_dual_pair: assert property (p_dual_pair) else $error("pair events split");
  property p_quad_all;
    bm == BM_QUAD && cksel == `RBC_LVL_LOW && !$changed(cfg_now) |=> ebuf_ins_cmd inside {4'h0, 4'hf};
  endproperty
  a_quad_all: assert property (p_quad_all) else $error("quad inserts not simultaneous");
  property p_rec_quiet;
    cksel == `RBC_LVL_HIGH && state_reg == ST_BONDED |=> ebuf_ins_cmd == 4'h0 && ebuf_del_cmd == 4'h0;
  endproperty
  a_rec_quiet: assert property (p_rec_quiet) else $error("insert on recovered clock");
  property p_ref_clk;
    cksel == `RBC_LVL_LOW |=> output_clock_a_src == CS_REF && !output_clock_bd_oe && ebuf_enable;
  endproperty
  a_ref_clk: assert property (p_ref_clk) else $error("reference clock steering wrong");
  property p_dual_clk;
    bm == BM_DUAL && cksel == `RBC_LVL_HIGH |=> output_clock_a_src == ($past(ab_sel) ? CS_REC_B : CS_REC_A);
  endproperty
  a_dual_clk: assert property (p_dual_clk) else $error("pair A/B clock wrong");
  property p_mid_inhibit;
    bm != BM_INDEP && cksel == `RBC_LVL_MID |=> bond_inhibit ##1 !words_aligned;
  endproperty
  a_mid_inhibit: assert property (p_mid_inhibit) else $error("bonding ran at MID source");
  property p_wired_and;
    multi && state_reg != ST_BONDED |=> bond_complete_oe && bond_complete_o == 1'b0;
  endproperty
  a_wired_and: assert property (p_wired_and) else $error("bond complete not pulled low");
endmodule : rbc_ctrl

// ==== dv/rbc_far_model.sv ====
// rbc_far_model: far side of the bonding block, link framer bursts and a second bonding device
// assumes the bench resolves the shared status bus and the wired-AND line from every enable
`timescale 1ns/1ns
module rbc_far_model (
  // bench controls
  input wire logic send_sync,
  input wire logic drive_bus,
  input wire logic [1:0] bus_event,
  input wire logic hold_low,
  // link side
  output logic link_clk,
  output logic framing_seen,
  // shared pins
  output logic [1:0] bus_o,
  output logic bus_oe,
  output logic complete_oe
);
  // the recovered clock ticks a few idle characters at power-up, so the link side sees the reset
  // then one burst per request: two idle characters, six framing characters, two idle ones
  // the idle lead-in lets a reset released while the clock stood still reach the link side
  // all remote transmitters share one reference, so one clock stands for every channel
  initial begin
    link_clk = 1'h0;
    framing_seen = 1'h0;
    repeat (4) begin
      #32 link_clk = 1'h1;
      #32 link_clk = 1'h0;
    end
    forever begin
      @(posedge send_sync);
      for (int n = 0; n < 10; n++) begin
        #32 link_clk = 1'h1;
        #1 framing_seen = (n >= 2 && n < 8);
        #31 link_clk = 1'h0;
      end
    end
  end

  // the other device drives the bus only while it is the controller
  assign bus_oe = drive_bus;
  assign bus_o = bus_event;
  // the other device pulls the wired-AND low while it is still resolving
  assign complete_oe = hold_low;
endmodule : rbc_far_model

// ==== dv/tb_top.sv ====
// tb_top: self-checking bench for rbc_ctrl with the far side model
// assumes a 20 MHz clock, a 64 ns link clock from the model, and a short re-enable count
`timescale 1ns/1ns
module tb_top
  import rbc_pkg::*;
();
  typedef struct packed {
    logic [3:0] md;
    logic [1:0] sr;
    logic [1:0] sl;
    logic [3:0] ir, dr, ei, ed;
    rbc_clk_src_t xa, xc;
  } rbc_row_t;
  logic clock, rst_n, csn, stb, send, hold, drv, m_oe, m_coe, link_clk, fseen;
  logic [3:0] mode, ins_r, del_r, flt, ai, ad;
  logic [1:0] src, ev, m_o, bsb, last_bs, bs_o;
  logic ab, cd, bs_oe, bc_o, bc_oe, bcl, eben, bdoe, csv, wal, inh, allb;
  logic [7:0] enb;
  logic [3:0] icmd, dcmd, pwr, lfi, sus;
  rbc_clk_src_t ca, cc;
  rbc_row_t r;
  int failures = 0;
  int num_checks = 0;
  // mode, source, {ab,cd}, ins req, del req, expected ins, expected del, clock a, clock c
  rbc_row_t rows [16] = '{
    '{4'h4, 2'h0, 2'h0, 4'h1, 4'h0, 4'h3, 4'h0, CS_REF, CS_REF},
    '{4'h4, 2'h0, 2'h2, 4'h1, 4'h0, 4'h0, 4'h0, CS_REF, CS_REF},
    '{4'h4, 2'h0, 2'h2, 4'h2, 4'h0, 4'h3, 4'h0, CS_REF, CS_REF},
    '{4'h4, 2'h0, 2'h1, 4'h0, 4'h8, 4'h0, 4'hc, CS_REF, CS_REF},
    '{4'h4, 2'h0, 2'h0, 4'h0, 4'h8, 4'h0, 4'h0, CS_REF, CS_REF},
    '{4'h4, 2'h0, 2'h0, 4'h1, 4'h1, 4'h3, 4'h0, CS_REF, CS_REF},
    '{4'h8, 2'h0, 2'h2, 4'h4, 4'h0, 4'hf, 4'h0, CS_REF, CS_REF},
    '{4'h8, 2'h0, 2'h1, 4'h0, 4'h2, 4'h0, 4'hf, CS_REF, CS_REF},
    '{4'h8, 2'h0, 2'h3, 4'h8, 4'h0, 4'hf, 4'h0, CS_REF, CS_REF},
    '{4'h8, 2'h0, 2'h0, 4'h2, 4'h0, 4'h0, 4'h0, CS_REF, CS_REF},
    '{4'h4, 2'h1, 2'h0, 4'h1, 4'h0, 4'h0, 4'h0, CS_REF, CS_REF},
    '{4'h5, 2'h0, 2'h0, 4'h1, 4'h0, 4'h0, 4'h0, CS_REF, CS_REF},
    '{4'h4, 2'h2, 2'h2, 4'h0, 4'h0, 4'h0, 4'h0, CS_REC_B, CS_REC_C},
    '{4'h4, 2'h2, 2'h1, 4'h0, 4'h0, 4'h0, 4'h0, CS_REC_A, CS_REC_D},
    '{4'h8, 2'h2, 2'h3, 4'h0, 4'h0, 4'h0, 4'h0, CS_REC_D, CS_REC_D},
    '{4'h8, 2'h2, 2'h1, 4'h0, 4'h0, 4'h0, 4'h0, CS_REC_B, CS_REC_B}};

  // an undriven status bus shows the inverse of its last level, so stale values never pass
  assign bsb = bs_oe ? bs_o : (m_oe ? m_o : ~last_bs);
  always_ff @(posedge clock) last_bs <= bsb;
  // wired-AND with pull-up: any pull-down enable wins
  assign bcl = ~(bc_oe | m_coe);

  rbc_ctrl #(.REEN_CYC(20)) rbc_ctrl_i (.clock(clock), .rst_n(rst_n), .link_clk(link_clk),
    .receive_bonding_mode_select(mode), .receive_clock_source_select(src), .pair_ab_clock_select(ab),
    .pair_cd_clock_select(cd), .controller_select_n(csn), .receive_enable_latch_strobe(stb),
    .channel_enable_bus(enb), .ebuf_ins_req(ins_r), .ebuf_del_req(del_r), .chan_fault_in(flt),
    .link_framing_seen(fseen), .bond_status_bus_i(bsb), .bond_status_bus_o(bs_o),
    .bond_status_bus_oe(bs_oe), .bond_complete_i(bcl), .bond_complete_o(bc_o),
    .bond_complete_oe(bc_oe), .ebuf_ins_cmd(icmd), .ebuf_del_cmd(dcmd), .ebuf_enable(eben),
    .output_clock_a_src(ca), .output_clock_c_src(cc), .output_clock_bd_oe(bdoe),
    .clock_select_valid(csv), .receive_power_en(pwr), .link_fault_indicator(lfi),
    .output_data_suspect(sus), .words_aligned(wal), .bond_inhibit(inh), .all_devices_bonded(allb));

  rbc_far_model rbc_far_model_i (.send_sync(send), .drive_bus(drv), .bus_event(ev), .hold_low(hold),
    .link_clk(link_clk), .framing_seen(fseen), .bus_o(m_o), .bus_oe(m_oe), .complete_oe(m_coe));

  // system clock, 50 ns period
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_src(input string n, input rbc_clk_src_t e, input rbc_clk_src_t g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_src

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // collects every command seen over a window, since bused events arrive a few edges late
  task automatic catch(output logic [3:0] oi, output logic [3:0] od);
    oi = 4'h0;
    od = 4'h0;
    repeat (8) begin
      @(negedge clock);
      oi = oi | icmd;
      od = od | dcmd;
    end
  endtask : catch

  task automatic pulse(input logic [3:0] i, input logic [3:0] d, output logic [3:0] oi, output logic [3:0] od);
    @(posedge clock);
    ins_r <= i;
    del_r <= d;
    @(posedge clock);
    ins_r <= 4'h0;
    del_r <= 4'h0;
    catch(oi, od);
  endtask : pulse

  // reset after every configuration change, then let the re-enable window run out
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    repeat (28) @(posedge clock);
  endtask : do_reset

  task automatic wait_al();
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clock);
      if (wal === 1'h1) break;
    end
    if (k == 300) begin
      failures++;
      $display("mismatch words_aligned expected 1 seen %b", wal);
      print_verdict();
    end
  endtask : wait_al

  // main sequence
  initial begin
    rst_n = 1'h0; mode = 4'h4; src = 2'h0; ab = 1'h0; cd = 1'h0; csn = 1'h0; stb = 1'h1;
    enb = 8'haa; ins_r = 4'h0; del_r = 4'h0; flt = 4'h0; send = 1'h0; hold = 1'h0; drv = 1'h0; ev = 2'h0;
    repeat (16) @(posedge clock);
    chk("power_in_reset", 4'h0, pwr);
    chk("fault_in_reset", 4'hf, lfi);
    rst_n <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      r = rows[i];
      @(posedge clock);
      mode <= r.md; src <= r.sr; ab <= r.sl[1]; cd <= r.sl[0];
      do_reset();
      pulse(r.ir, r.dr, ai, ad);
      chk("ins_cmd", r.ei, ai);
      chk("del_cmd", r.ed, ad);
      chk("inhibit", {3'h0, (r.sr == 2'h1) | (r.md[1:0] == 2'h1)}, {3'h0, inh});
      if (r.sr != 2'h1) begin
        chk_src("clock_a", r.xa, ca);
        chk_src("clock_c", r.xc, cc);
        chk("ebuf_enable", 4'h1, {3'h0, eben});
      end
      if (r.sr == 2'h0) chk("bd_oe", 4'h0, {3'h0, bdoe});
      $display("row %0d done", i);
    end
    // latch holds once the strobe falls
    @(posedge clock) stb <= 1'h0;
    @(posedge clock) enb <= 8'h00;
    repeat (6) @(negedge clock);
    chk("power_held", 4'hf, pwr);
    // master B, then only channel A powered
    @(posedge clock);
    mode <= 4'h8; src <= 2'h0; ab <= 1'h0; cd <= 1'h1;
    do_reset();
    chk("power_after_reset", 4'h0, pwr);
    @(posedge clock) begin stb <= 1'h1; enb <= 8'h02; end
    repeat (3) @(posedge clock);
    stb <= 1'h0;
    @(posedge clock) enb <= 8'h00;
    repeat (4) @(negedge clock);
    chk("power_a_only", 4'h1, pwr);
    chk("fault_disabled", 4'h7, {1'h0, lfi[3:1]});
    chk("suspect_a", 4'h1, {3'h0, sus[0]});
    @(posedge clock) flt <= 4'h1;
    @(posedge clock) flt <= 4'h0;
    @(negedge clock);
    chk("fault_passed", 4'h1, {3'h0, lfi[0]});
    pulse(4'h2, 4'h0, ai, ad);
    chk("ins_dead_master", 4'h0, ai);
    repeat (30) @(negedge clock);
    chk("suspect_a_later", 4'h0, {3'h0, sus[0]});
    $display("power test done");
    // multi-device bonding with this device as controller
    @(posedge clock) begin stb <= 1'h1; enb <= 8'haa; cd <= 1'h0; hold <= 1'h1; end
    do_reset();
    chk("complete_oe", 4'h1, {3'h0, bc_oe});
    chk("complete_o", 4'h0, {3'h0, bc_o});
    chk("all_bonded", 4'h0, {3'h0, allb});
    chk("bus_oe_ctrl", 4'h1, {3'h0, bs_oe});
    @(posedge clock) send <= 1'h1;
    wait_al();
    repeat (3) @(negedge clock);
    chk("complete_oe_done", 4'h0, {3'h0, bc_oe});
    @(posedge clock) hold <= 1'h0;
    repeat (5) @(negedge clock);
    chk("all_bonded_done", 4'h1, {3'h0, allb});
    // another device controls the status bus
    @(posedge clock) begin csn <= 1'h1; drv <= 1'h1; send <= 1'h0; end
    do_reset();
    chk("bus_oe", 4'h0, {3'h0, bs_oe});
    @(posedge clock) ev <= 2'h1;
    @(posedge clock) ev <= 2'h0;
    catch(ai, ad);
    chk("ins_from_bus", 4'hf, ai);
    $display("multi-device test done");
    // recovered clock: no insert or delete once bonded
    @(posedge clock) begin csn <= 1'h0; drv <= 1'h0; mode <= 4'h4; src <= 2'h2; end
    do_reset();
    @(posedge clock) send <= 1'h1;
    wait_al();
    chk("clock_valid", 4'h1, {3'h0, csv});
    pulse(4'h1, 4'h0, ai, ad);
    chk("ins_recovered", 4'h0, ai);
    pulse(4'h0, 4'h1, ai, ad);
    chk("del_recovered", 4'h0, ad);
    $display("recovered clock test done");
    print_verdict();
  end
endmodule : tb_top
